// ==== design/alz_averager.sv ====
`timescale 1ns/1ps
`include "alz_defs.svh"
module alz_averager #(
  parameter int SUM_W = 20,
  parameter int CNT_W = 12
) (
  input  wire logic             clk,
  input  wire logic             rst,
  input  wire logic             clear,
  input  wire logic             smp_valid,
  input  wire logic [7:0]       smp,
  input  wire logic             close,
  output logic      [7:0]       avg_reg,
  output logic                  avg_valid_reg
);
  import alz_pkg::*;

  logic [SUM_W-1:0] sum_reg, sum_next, tot;
  logic [CNT_W-1:0] cnt_reg, cnt_next, num;
  logic [7:0]       avg_next;
  logic             avg_valid_next;

  // ==========================================================
  // accumulate
  always_comb begin
    tot            = sum_reg + (smp_valid ? SUM_W'(smp) : SUM_W'(0));
    num            = cnt_reg + (smp_valid ? CNT_W'(1) : CNT_W'(0));
    sum_next       = tot;
    cnt_next       = num;
    avg_next       = avg_reg;
    avg_valid_next = 1'b0;
    if (clear) begin
      sum_next = '0;
      cnt_next = '0;
    end else if (close) begin
      // a sample landing on the closing edge still counts for this period
      if (num != '0) begin
        avg_next       = 8'(tot / SUM_W'(num));
        avg_valid_next = 1'b1;
      end
      sum_next = '0;
      cnt_next = '0;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      sum_reg       <= '0;
      cnt_reg       <= '0;
      avg_reg       <= `ALZ_RESULT_RST;
      avg_valid_reg <= 1'b0;
    end else begin
      sum_reg       <= sum_next;
      cnt_reg       <= cnt_next;
      avg_reg       <= avg_next;
      avg_valid_reg <= avg_valid_next;
    end
  end

endmodule : alz_averager

// ==== design/alz_defs.svh ====
`ifndef ALZ_DEFS_SVH
`define ALZ_DEFS_SVH

// ==========================================================
// register map
`define ALZ_RESULT_ADDR    8'h38
`define ALZ_RESULT_RST     8'h00
`define ALZ_PER_SEL_MSB    5
`define ALZ_PER_SEL_LSB    3

// ==========================================================
// zone and period counts
`define ALZ_ZONE_TOP       3'd4
`define ALZ_FAST_PERIODS   2'd3
`define ALZ_NEED_PERIODS   6'd3
`define ALZ_DOWN_BASE      6'd3

// ==========================================================
// timing
`define ALZ_CLK_NS         20
`define ALZ_SAMPLE_NS      140000
`define ALZ_FAST_NS        1100000
`define ALZ_UNIT_NS        1100000

`endif

// ==== design/alz_mapper.sv ====
`timescale 1ns/1ps
`include "alz_defs.svh"
module alz_mapper (
  input  wire logic              clk,
  input  wire logic              rst,
  input  wire logic              clear,
  input  wire logic              startup,
  input  wire logic              zone_valid,
  input  wire alz_pkg::alz_zone_t zone,
  input  wire alz_pkg::alz_algo_t algo,
  input  wire logic [4:0]        down_code,
  output alz_pkg::alz_zone_t     target_zone_reg,
  output logic                   target_update_reg
);
  import alz_pkg::*;

  alz_dir_t  dir_reg, dir_next, new_dir;
  logic [5:0] cnt_reg, cnt_next, need;
  logic      met_reg, met_next, force_req, allowed, up, dn, upd_next;
  alz_zone_t prev_reg, prev_next, tgt_next;

  // ==========================================================
  // consecutive-period tracking, own copy per mapper
  always_comb begin
    dir_next  = dir_reg;
    cnt_next  = cnt_reg;
    met_next  = met_reg;
    prev_next = prev_reg;
    tgt_next  = target_zone_reg;
    upd_next  = 1'b0;
    force_req = 1'b0;
    up        = zone > prev_reg;
    dn        = zone < prev_reg;
    new_dir   = up ? DIR_UP : DIR_DOWN;
    if (clear) begin
      dir_next  = DIR_NONE;
      cnt_next  = '0;
      met_next  = 1'b0;
      prev_next = '0;
      tgt_next  = '0;
    end else if (zone_valid) begin // R13
      prev_next = zone;
      if (startup) begin
        // fast start-up: target follows the zone so it settles quickly
        dir_next  = DIR_NONE;
        cnt_next  = '0;
        met_next  = 1'b0;
        force_req = 1'b1;
      end else if (met_reg) begin
        if ((up && dir_reg == DIR_UP) || (dn && dir_reg == DIR_DOWN)) begin
          force_req = 1'b1; // R10
        end else if (up || dn) begin
          dir_next = new_dir; // R11
          cnt_next = 6'd1;
          met_next = 1'b0;
        end else begin
          dir_next = DIR_NONE; // R11
          cnt_next = '0;
          met_next = 1'b0;
        end
      end else begin
        if (up || dn) begin
          if (new_dir == dir_reg) begin
            cnt_next = cnt_reg + 6'd1; // R8 R9
          end else begin
            dir_next = new_dir;
            cnt_next = 6'd1;
          end
        end else if (dir_reg != DIR_NONE) begin
          cnt_next = cnt_reg + 6'd1; // R8 R9
        end
        if (dir_next != DIR_NONE && cnt_next >= need) begin
          met_next  = 1'b1;
          force_req = 1'b1;
        end
      end
      if (force_req && allowed && zone != target_zone_reg) begin
        tgt_next = zone; // R14
        upd_next = 1'b1;
      end
    end
  end

  // ==========================================================
  // algorithm selection
  always_comb begin
    need = `ALZ_NEED_PERIODS; // R8
    if (dir_next == DIR_DOWN && algo == ALGO_DOWN_DELAY) begin
      need = `ALZ_NEED_PERIODS + `ALZ_DOWN_BASE + {1'b0, down_code}; // R20
    end
    // direct moves both ways; outside start-up, up-only ignores down criteria and any move to a lower target
    allowed = startup || algo != ALGO_UP_ONLY || // R7 R15 R16
      (dir_next != DIR_DOWN && zone > target_zone_reg);
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      dir_reg           <= DIR_NONE;
      cnt_reg           <= '0;
      met_reg           <= 1'b0;
      prev_reg          <= '0;
      target_zone_reg   <= '0;
      target_update_reg <= 1'b0;
    end else begin
      dir_reg           <= dir_next;
      cnt_reg           <= cnt_next;
      met_reg           <= met_next;
      prev_reg          <= prev_next;
      target_zone_reg   <= tgt_next;
      target_update_reg <= upd_next;
    end
  end

  // ==========================================================
  // checks
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  force_zone_a: assert property (target_update_reg |-> target_zone_reg == $past(zone)) // R14
    else $error("target not taken from averager zone");
  at_boundary_a: assert property (target_update_reg |-> $past(zone_valid)) // R13
    else $error("target moved off a period boundary");
  up_only_a: assert property (target_update_reg && $past(algo) == ALGO_UP_ONLY && // R16
      !$past(startup) |-> target_zone_reg > $past(target_zone_reg))
    else $error("up-only mapper lowered its target");
  need_met_a: assert property (target_update_reg && !$past(startup) && !$past(met_reg) // R8
      |-> $past(cnt_next) >= $past(need))
    else $error("target moved before enough periods");

  cover property (target_update_reg && !$past(startup));
  cover property (met_reg && dir_reg == DIR_DOWN && algo == ALGO_DOWN_DELAY);

endmodule : alz_mapper

// ==== design/alz_pkg.sv ====
package alz_pkg;

  typedef logic [2:0] alz_zone_t;

  typedef enum logic [1:0] {
    ALGO_DIRECT,
    ALGO_UP_ONLY,
    ALGO_DOWN_DELAY
  } alz_algo_t;

  typedef enum logic [1:0] {
    DIR_NONE,
    DIR_UP,
    DIR_DOWN
  } alz_dir_t;

  typedef enum logic [1:0] {
    ST_OFF,
    ST_FAST,
    ST_RUN
  } alz_state_t;

  typedef struct packed {
    logic [7:0] high;
    logic [7:0] low;
  } alz_bound_t;

endpackage : alz_pkg

// ==== design/alz_tracker.sv ====
// Operation
// R1: average all samples of one period; period chosen by config bits 5 to 3.
// R2: while enabled, refresh the readable average at 0x38 every period.
// R3: at each period end store the zone of the averaged voltage.
// R4: starting the sensor interface puts the zone at zone 0.
// R5: during start-up use a fast 1.1 ms average period.
// R6: start-up lasts three fast periods, then the programmed period applies.
// R7: each of three mappers picks direct, up-only or down-delay.
// R8: raise target only after three consecutive rising or rose-and-held periods.
// R9: lower target only after three consecutive falling or fell-and-held periods.
// R10: after the criterion, a further same-way change moves target at once.
// R11: after the criterion, no change or reversal needs the full criterion again.
// R12: averager output holds the zone of the last finished period.
// R13: target changes happen only at a period boundary.
// R14: a forced change takes the target indexed by the averager zone.
// R15: direct mode moves the target up and down.
// R16: up-only mode never lowers the target; in start-up the code lets the target follow the zone down.
// R17: five zones from four boundary pairs of 8-bit high and low.
// R18: go up only above the high threshold, down only below low.
// R19: while enabled, take a sample every 140 us.
// R20: down-delay adds code plus 3 extra periods before lowering.
// R21: re-enabling resets zone, counters and repeats the fast start-up.
// R22: each mapper keeps its own counters and direction.
`timescale 1ns/1ps
`include "alz_defs.svh"
module alz_tracker #(
  parameter int CNT_W         = 24,
  parameter int SAMPLE_CYCLES = (`ALZ_SAMPLE_NS + `ALZ_CLK_NS - 1) / `ALZ_CLK_NS,
  parameter int FAST_CYCLES   = (`ALZ_FAST_NS + `ALZ_CLK_NS - 1) / `ALZ_CLK_NS,
  parameter int UNIT_CYCLES   = (`ALZ_UNIT_NS + `ALZ_CLK_NS - 1) / `ALZ_CLK_NS
) (
  input  wire logic                     clk,
  input  wire logic                     rst,
  input  wire logic                     als_enable,
  input  wire logic [7:0]               als_config,
  input  wire alz_pkg::alz_algo_t [2:0] mapper_algo,
  input  wire logic [4:0]               down_delay_code,
  input  wire alz_pkg::alz_bound_t [3:0] zone_bound,
  input  wire logic                     adc_valid,
  input  wire logic [7:0]               adc_data,
  input  wire logic [7:0]               reg_addr,
  output logic                          adc_start,
  output logic [7:0]                    reg_rd_data,
  output logic [7:0]                    avg_result,
  output alz_pkg::alz_zone_t            averager_zone,
  output alz_pkg::alz_zone_t [2:0]      target_zone,
  output logic [2:0]                    target_update,
  output logic                          startup_active
);
  import alz_pkg::*;

  alz_state_t       st_reg, st_next;
  logic [1:0]       fast_cnt_reg, fast_cnt_next;
  logic [CNT_W-1:0] per_cnt_reg, per_cnt_next, per_len;
  logic [CNT_W-1:0] smp_cnt_reg, smp_cnt_next;
  logic             per_end_reg, per_end_next;
  logic             adc_start_reg, adc_start_next;
  logic             en_q_reg, clr;
  logic             end_fast_reg, end_fast_next;
  logic             avg_fast_reg, avg_fast_next;
  logic             zone_valid_reg, zone_valid_next;
  logic             zone_fast_reg, zone_fast_next;
  logic             startup_reg, startup_next;
  alz_zone_t        zone_reg, zone_next;
  logic [7:0]       avg_out, avg_result_reg, avg_result_next;
  logic [7:0]       rd_data_reg, rd_data_next;
  logic             avg_valid;

  // ==========================================================
  // start and restart detection
  // a rising enable clears the divider, averager sums, zone and mappers; the last average result is kept
  assign clr = !als_enable || !en_q_reg; // R21

  always_ff @(posedge clk) begin
    if (rst) begin
      en_q_reg <= 1'b0;
    end else begin
      en_q_reg <= als_enable;
    end
  end

  // ==========================================================
  // sample request divider
  always_comb begin
    smp_cnt_next   = smp_cnt_reg + CNT_W'(1);
    adc_start_next = 1'b0;
    if (clr) begin
      smp_cnt_next = '0;
    end else if (smp_cnt_reg == CNT_W'(SAMPLE_CYCLES - 1)) begin
      smp_cnt_next   = '0;
      adc_start_next = 1'b1; // R19
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      smp_cnt_reg   <= '0;
      adc_start_reg <= 1'b0;
    end else begin
      smp_cnt_reg   <= smp_cnt_next;
      adc_start_reg <= adc_start_next;
    end
  end

  // ==========================================================
  // start-up sequencer and average period timer
  always_comb begin
    if (st_reg == ST_FAST) begin
      per_len = CNT_W'(FAST_CYCLES); // R5
    end else begin
      per_len = CNT_W'(UNIT_CYCLES) * // R1
        CNT_W'({1'b0, als_config[`ALZ_PER_SEL_MSB:`ALZ_PER_SEL_LSB]} + 4'd1);
    end
  end

  always_comb begin
    st_next       = st_reg;
    fast_cnt_next = fast_cnt_reg;
    per_cnt_next  = per_cnt_reg + CNT_W'(1);
    per_end_next  = 1'b0;
    end_fast_next = 1'b0;
    if (!als_enable) begin
      st_next       = ST_OFF;
      fast_cnt_next = '0;
      per_cnt_next  = '0;
    end else if (!en_q_reg) begin
      st_next       = ST_FAST; // R21
      fast_cnt_next = '0;
      per_cnt_next  = '0;
    end else if (per_cnt_reg == per_len - CNT_W'(1)) begin
      per_cnt_next  = '0;
      per_end_next  = 1'b1;
      end_fast_next = st_reg == ST_FAST;
      if (st_reg == ST_FAST) begin
        fast_cnt_next = fast_cnt_reg + 2'd1;
        if (fast_cnt_next == `ALZ_FAST_PERIODS) begin
          st_next = ST_RUN; // R6
        end
      end
    end
    startup_next = st_next == ST_FAST;
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      st_reg       <= ST_OFF;
      fast_cnt_reg <= '0;
      per_cnt_reg  <= '0;
      per_end_reg  <= 1'b0;
      end_fast_reg <= 1'b0;
      startup_reg  <= 1'b0;
    end else begin
      st_reg       <= st_next;
      fast_cnt_reg <= fast_cnt_next;
      per_cnt_reg  <= per_cnt_next;
      per_end_reg  <= per_end_next;
      end_fast_reg <= end_fast_next;
      startup_reg  <= startup_next;
    end
  end

  // ==========================================================
  // sample averager
  alz_averager #(
    .SUM_W (20),
    .CNT_W (12)
  ) u_averager (
    .clk           (clk),
    .rst           (rst),
    .clear         (clr),
    .smp_valid     (adc_valid),
    .smp           (adc_data),
    .close         (per_end_reg),
    .avg_reg       (avg_out),
    .avg_valid_reg (avg_valid)
  );

  // ==========================================================
  // zone decision with hysteresis
  function automatic alz_zone_t classify(input alz_zone_t z, input logic [7:0] v,
                                         input alz_bound_t [3:0] b);
    alz_zone_t r;
    r = z;
    for (int i = 0; i < 4; i++) begin
      if (r < `ALZ_ZONE_TOP && v > b[2'(r)].high) begin
        r = r + 3'd1; // R17 R18
      end
    end
    for (int i = 0; i < 4; i++) begin
      if (r > 3'd0 && v < b[2'(r - 3'd1)].low) begin
        r = r - 3'd1; // R17 R18
      end
    end
    return r;
  endfunction : classify

  always_comb begin
    zone_next       = zone_reg;
    avg_result_next = avg_result_reg;
    avg_fast_next   = per_end_reg ? end_fast_reg : avg_fast_reg;
    zone_valid_next = 1'b0;
    zone_fast_next  = 1'b0;
    if (clr) begin
      zone_next = '0; // R4
    end else if (avg_valid) begin
      // updated only at a period end, so it lags the period in progress
      zone_next       = classify(zone_reg, avg_out, zone_bound); // R3 R12
      avg_result_next = avg_out; // R2
      zone_valid_next = 1'b1;
      zone_fast_next  = avg_fast_reg;
    end
    rd_data_next = (reg_addr == `ALZ_RESULT_ADDR) ? avg_result_reg : 8'h00; // R2
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      zone_reg       <= '0;
      avg_result_reg <= `ALZ_RESULT_RST;
      avg_fast_reg   <= 1'b0;
      zone_valid_reg <= 1'b0;
      zone_fast_reg  <= 1'b0;
      rd_data_reg    <= 8'h00;
    end else begin
      zone_reg       <= zone_next;
      avg_result_reg <= avg_result_next;
      avg_fast_reg   <= avg_fast_next;
      zone_valid_reg <= zone_valid_next;
      zone_fast_reg  <= zone_fast_next;
      rd_data_reg    <= rd_data_next;
    end
  end

  // ==========================================================
  // zone mappers: index 0, 1, 2 are zone_mapper_one, two, three
  for (genvar m = 0; m < 3; m++) begin : zone_mapper
    alz_mapper u_map ( // R7 R22
      .clk               (clk),
      .rst               (rst),
      .clear             (clr),
      .startup           (zone_fast_reg),
      .zone_valid        (zone_valid_reg),
      .zone              (zone_reg),
      .algo              (mapper_algo[m]),
      .down_code         (down_delay_code),
      .target_zone_reg   (target_zone[m]),
      .target_update_reg (target_update[m])
    );
  end

  assign adc_start      = adc_start_reg;
  assign reg_rd_data    = rd_data_reg;
  assign avg_result     = avg_result_reg;
  assign averager_zone  = zone_reg;
  assign startup_active = startup_reg;

  // ==========================================================
  // checks
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  period_len_a: assert property (per_end_reg && $past(st_reg) == ST_RUN && // R1
      $past(st_reg, 2) == ST_RUN |-> $past(per_cnt_reg) == $past(per_len) - CNT_W'(1))
    else $error("average period length wrong");
  result_upd_a: assert property (avg_valid && !clr |=> avg_result_reg == $past(avg_out)) // R2
    else $error("average result not refreshed");
  read_port_a: assert property (reg_addr == `ALZ_RESULT_ADDR |=> // R2
      reg_rd_data == $past(avg_result_reg))
    else $error("read at result address wrong");
  zone_hold_a: assert property ($changed(zone_reg) |-> $past(avg_valid) || $past(clr)) // R12
    else $error("zone moved inside a period");
  zone_init_a: assert property ($rose(als_enable) |=> zone_reg == 3'd0 && st_reg == ST_FAST) // R4
    else $error("start-up did not reset zone");
  fast_len_a: assert property (per_end_reg && $past(st_reg) == ST_FAST && // R5
      !$past(clr) |-> $past(per_cnt_reg) == CNT_W'(FAST_CYCLES - 1))
    else $error("fast period length wrong");
  fast_three_a: assert property (st_reg == ST_RUN && $past(st_reg) == ST_FAST |-> // R6
      $past(fast_cnt_reg) == 2'd2)
    else $error("start-up did not last three periods");
  hyst_up_a: assert property (avg_valid && !clr && zone_reg != 3'd4 && // R18
      avg_out <= zone_bound[2'(zone_reg)].high |=> zone_reg <= $past(zone_reg))
    else $error("zone rose without crossing high threshold");
  hyst_dn_a: assert property (avg_valid && !clr && zone_reg != 3'd0 && // R18
      avg_out >= zone_bound[2'(zone_reg - 3'd1)].low |=> zone_reg >= $past(zone_reg))
    else $error("zone fell without crossing low threshold");
  sample_gap_a: assert property (adc_start_reg |-> // R19
      $past(smp_cnt_reg) == CNT_W'(SAMPLE_CYCLES - 1))
    else $error("sample request spacing wrong");
  restart_a: assert property (!als_enable |=> zone_reg == 3'd0 && st_reg == ST_OFF) // R21
    else $error("disable did not clear the sequence");

  cover property (st_reg == ST_RUN && $past(st_reg) == ST_FAST);
  cover property (zone_reg == 3'd4);
  cover property (|target_update && st_reg == ST_RUN);

endmodule : alz_tracker

// ==== dv/alz_sensor_model.sv ====
`timescale 1ns/1ps
// ==========================================================
// light sensor plus converter as seen by the tracker
module alz_sensor_model #(
  parameter int CONV_CYCLES = 3
) (
  input  wire logic       clk,
  input  wire logic       rst,
  input  wire logic       adc_start,
  input  wire logic [7:0] level,
  output logic            adc_valid,
  output logic [7:0]      adc_data
);
  logic [3:0] wait_cnt;

  // result comes CONV_CYCLES after each request; slow answers via the parameter
  always @(posedge clk) begin
    if (rst) begin
      wait_cnt  <= 4'h0;
      adc_valid <= 1'b0;
      adc_data  <= 8'h00;
    end else begin
      adc_valid <= 1'b0;
      // no stale value between results, so a mistimed capture shows up
      adc_data  <= ~adc_data;
      if (adc_start) begin
        wait_cnt <= CONV_CYCLES[3:0];
      end else if (wait_cnt != 4'h0) begin
        wait_cnt <= wait_cnt - 4'h1;
        if (wait_cnt == 4'h1) begin
          adc_valid <= 1'b1;
          adc_data  <= level;
        end
      end
    end
  end
endmodule : alz_sensor_model

// ==== dv/test_ambient_light_zone_tracker.sv ====
`timescale 1ns/1ps
`define CHK(what, exp, got) \
  begin \
    n_checks++; \
    if ((got) !== (exp)) begin \
      err_total++; \
      $display("CHECK FAILED %s expected %0h seen %0h", what, exp, got); \
    end \
  end
module test_ambient_light_zone_tracker;
  import alz_pkg::*;
  // ==========================================================
  // levels well inside each zone; LVH sits in the hysteresis band of bound 2
  localparam logic [7:0] LV0 = 8'h14;
  localparam logic [7:0] LV1 = 8'h46;
  localparam logic [7:0] LV2 = 8'h78;
  localparam logic [7:0] LV3 = 8'haa;
  localparam logic [7:0] LV4 = 8'he6;
  localparam logic [7:0] LVH = 8'h91;
  logic                  clk;
  logic                  rst;
  logic                  als_enable;
  logic                  adc_valid;
  logic                  adc_start;
  logic                  startup_active;
  logic [4:0]            down_delay_code;
  logic [2:0]            target_update;
  logic [7:0]            als_config, adc_data, reg_addr, reg_rd_data, avg_result, level;
  alz_algo_t [2:0]       mapper_algo;
  alz_bound_t [3:0]      zone_bound;
  alz_zone_t             averager_zone;
  alz_zone_t [2:0]       target_zone;
  int                    err_total;
  int                    n_checks;
  int                    per_len;

  alz_tracker #(.SAMPLE_CYCLES(20), .FAST_CYCLES(200), .UNIT_CYCLES(200)) DUT (
    .clk(clk), .rst(rst), .als_enable(als_enable), .als_config(als_config),
    .mapper_algo(mapper_algo), .down_delay_code(down_delay_code),
    .zone_bound(zone_bound), .adc_valid(adc_valid), .adc_data(adc_data),
    .reg_addr(reg_addr), .adc_start(adc_start), .reg_rd_data(reg_rd_data),
    .avg_result(avg_result), .averager_zone(averager_zone),
    .target_zone(target_zone), .target_update(target_update),
    .startup_active(startup_active)
  );

  alz_sensor_model #(.CONV_CYCLES(3)) sensor (
    .clk(clk), .rst(rst), .adc_start(adc_start), .level(level),
    .adc_valid(adc_valid), .adc_data(adc_data)
  );

  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end

  task automatic stop_test();
    if (err_total == 0 && n_checks > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : stop_test

  // ==========================================================
  // wait for a known result, then stand one edge after it (aligned to periods)
  task automatic sync_on(input logic [7:0] v);
    int n;
    n = 0;
    while (avg_result !== v && n < 2000) begin
      @(posedge clk);
      #1;
      n++;
    end
    if (n == 2000) begin
      err_total++;
      stop_test();
    end
    @(posedge clk);
    #1;
  endtask : sync_on

  // one whole period at one input level; 3'h7 skips a target check
  task automatic step(input logic [7:0] lv, input alz_zone_t z, t1, t2, t3);
    int starts;
    int ups [3];
    logic [7:0] prev;
    alz_zone_t te [3];
    alz_zone_t [2:0] old;
    starts = 0;
    ups = '{0, 0, 0};
    prev = level;
    old = target_zone;
    te = '{t1, t2, t3};
    for (int i = 0; i < per_len; i++) begin
      @(posedge clk);
      if (i == 0) level <= lv;
      #1;
      if (adc_start === 1'b1) starts++;
      for (int k = 0; k < 3; k++) begin
        if (target_update[k] === 1'b1) ups[k]++;
      end
    end
    `CHK("sample count", per_len / 20, starts)
    `CHK("averager zone", z, averager_zone)
    if (lv == prev) begin
      `CHK("average", lv, avg_result)
      `CHK("read 0x38", lv, reg_rd_data)
    end
    for (int k = 0; k < 3; k++) begin
      if (te[k] != 3'h7) `CHK("target", te[k], target_zone[k])
      if (te[k] != 3'h7) `CHK("target pulse", (te[k] != old[k]) ? 1 : 0, ups[k])
    end
  endtask : step

  task automatic check_restart();
    `CHK("start zone", 3'h0, averager_zone)
    `CHK("start targets", 9'h000, target_zone)
    `CHK("start-up flag", 1'b1, startup_active)
  endtask : check_restart

  initial begin
    rst = 1'b1;
    als_enable = 1'b0;
    als_config = 8'h00;
    down_delay_code = 5'h00;
    reg_addr = 8'h38;
    level = LV4;
    per_len = 200;
    err_total = 0;
    n_checks = 0;
    mapper_algo[0] = ALGO_DIRECT;
    mapper_algo[1] = ALGO_UP_ONLY;
    mapper_algo[2] = ALGO_DOWN_DELAY;
    zone_bound[0] = '{high: 8'h32, low: 8'h28};
    zone_bound[1] = '{high: 8'h64, low: 8'h5a};
    zone_bound[2] = '{high: 8'h96, low: 8'h8c};
    zone_bound[3] = '{high: 8'hc8, low: 8'hbe};
    repeat (16) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    #1;
    `CHK("reset result", 8'h00, reg_rd_data)
    // ========================================================
    // direct mode walk, up-only held high
    @(posedge clk);
    als_enable <= 1'b1;
    repeat (3) @(posedge clk);
    #1;
    check_restart();
    sync_on(LV4);
    step(LV4, 3'h4, 3'h4, 3'h4, 3'h4);
    `CHK("fast phase", 1'b1, startup_active)
    step(LV4, 3'h4, 3'h4, 3'h4, 3'h4);
    `CHK("fast phase over", 1'b0, startup_active)
    step(LV3, 3'h3, 3'h4, 3'h4, 3'h7);
    step(LV3, 3'h3, 3'h4, 3'h4, 3'h7);
    step(LV2, 3'h2, 3'h2, 3'h4, 3'h7);
    step(LV1, 3'h1, 3'h1, 3'h4, 3'h7);
    step(LV2, 3'h2, 3'h1, 3'h4, 3'h7);
    step(LV3, 3'h3, 3'h1, 3'h4, 3'h7);
    step(LV3, 3'h3, 3'h3, 3'h4, 3'h7);
    step(LVH, 3'h3, 3'h3, 3'h4, 3'h7);
    step(LV4, 3'h4, 3'h3, 3'h4, 3'h7);
    step(LV4, 3'h4, 3'h3, 3'h4, 3'h7);
    step(LV4, 3'h4, 3'h4, 3'h4, 3'h7);
    // ========================================================
    // restart, up-only walk on two mappers, down-delay never reached
    @(posedge clk);
    als_enable <= 1'b0;
    level <= LV1;
    mapper_algo[0] <= ALGO_UP_ONLY;
    repeat (3) @(posedge clk);
    als_enable <= 1'b1;
    repeat (3) @(posedge clk);
    #1;
    check_restart();
    sync_on(LV1);
    step(LV1, 3'h1, 3'h1, 3'h1, 3'h1);
    step(LV1, 3'h1, 3'h1, 3'h1, 3'h1);
    step(LV0, 3'h0, 3'h1, 3'h1, 3'h1);
    step(LV0, 3'h0, 3'h1, 3'h1, 3'h1);
    step(LV0, 3'h0, 3'h1, 3'h1, 3'h1);
    step(LV2, 3'h2, 3'h1, 3'h1, 3'h1);
    step(LVH, 3'h2, 3'h1, 3'h1, 3'h1);
    step(LV2, 3'h2, 3'h2, 3'h2, 3'h2);
    step(LV3, 3'h3, 3'h3, 3'h3, 3'h3);
    step(LV3, 3'h3, 3'h3, 3'h3, 3'h3);
    step(LV4, 3'h4, 3'h3, 3'h3, 3'h3);
    step(LV4, 3'h4, 3'h3, 3'h3, 3'h3);
    step(LV4, 3'h4, 3'h4, 3'h4, 3'h4);
    // ========================================================
    // longer programmed period, three algorithms side by side
    @(posedge clk);
    als_config <= 8'h08;
    down_delay_code <= 5'h02;
    mapper_algo[0] <= ALGO_DIRECT;
    per_len = 400;
    step(LV2, 3'h2, 3'h4, 3'h4, 3'h4);
    step(LV2, 3'h2, 3'h4, 3'h4, 3'h4);
    step(LV2, 3'h2, 3'h2, 3'h4, 3'h4);
    step(LV2, 3'h2, 3'h2, 3'h4, 3'h4);
    step(LV2, 3'h2, 3'h2, 3'h4, 3'h4);
    step(LV2, 3'h2, 3'h2, 3'h4, 3'h4);
    step(LV2, 3'h2, 3'h2, 3'h4, 3'h4);
    step(LV2, 3'h2, 3'h2, 3'h4, 3'h2);
    @(posedge clk);
    reg_addr <= 8'h39;
    @(posedge clk);
    #1;
    `CHK("unmapped read", 8'h00, reg_rd_data)
    @(posedge clk);
    reg_addr <= 8'h38;
    @(posedge clk);
    #1;
    `CHK("read 0x38", LV2, reg_rd_data)
    stop_test();
  end
endmodule : test_ambient_light_zone_tracker
